/* rpi_port_irq.sv */
// Receive-port interrupt enable and status registers with interrupt request.
//
// Notes on behaviour
// - Encode-error enable, high bit 2, lets link encode errors raise an interrupt.
// - Sequence-error enable, high bit 1, lets control-channel sequence errors interrupt.
// - CRC enable, high bit 0, lets control-channel CRC failures raise an interrupt.
// - Parity enable, low bit 2, lets link parity errors raise an interrupt.
// - Port-valid enable, low bit 1, interrupts on every port-valid change.
// - Lock enable, low bit 0, interrupts on every lock status change.
// - Encode error flag sits in high status bit 2; cleared by reading status two.
// - Sequence error flag sits in high status bit 1; cleared by reading status one.
// - CRC error flag sits in high status bit 0; cleared by reading status one.
// - Parity error flag sits in low status bit 2; cleared by reading status one.
// - Port-valid change flag sits in low status bit 1; cleared by status one read.
// - Lock change flag sits in low status bit 0; cleared by reading status one.
`timescale 1ns/10ps
module rpi_port_irq
  import rpi_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic ENCODE_ERROR_I,
  input wire logic CTL_SEQUENCE_ERROR_I,
  input wire logic CTL_CRC_ERROR_I,
  input wire logic PARITY_ERROR_I,
  input wire logic PORT_VALID_I,
  input wire logic LOCK_I,
  input wire logic STATUS_ONE_READ_I,
  input wire logic STATUS_TWO_READ_I,
  output logic IRQ_O
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic rpi_sel_t decode_addr(input logic [7:0] addr);
    rpi_sel_t sel;
    case (addr)
      RPI_ADDR_ENABLE_HIGH: sel = RPI_SEL_ENABLE_HIGH;
      RPI_ADDR_ENABLE_LOW: sel = RPI_SEL_ENABLE_LOW;
      RPI_ADDR_STATUS_HIGH: sel = RPI_SEL_STATUS_HIGH;
      RPI_ADDR_STATUS_LOW: sel = RPI_SEL_STATUS_LOW;
      default: sel = RPI_SEL_NONE;
    endcase
    return sel;
  endfunction

  rpi_sel_t sel;
  assign sel = decode_addr(REG_ADDR_I);

  // ****************************************
  // Enable registers
  // ****************************************
  logic [RPI_FIELD_WIDTH-1:0] enable_high_reg;
  logic [RPI_FIELD_WIDTH-1:0] enable_low_reg;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      enable_high_reg <= RPI_ENABLE_RESET[RPI_FIELD_WIDTH-1:0];
    end else if (REG_WR_I && sel == RPI_SEL_ENABLE_HIGH) begin
      enable_high_reg <= REG_WDATA_I[RPI_FIELD_WIDTH-1:0];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      enable_low_reg <= RPI_ENABLE_RESET[RPI_FIELD_WIDTH-1:0];
    end else if (REG_WR_I && sel == RPI_SEL_ENABLE_LOW) begin
      enable_low_reg <= REG_WDATA_I[RPI_FIELD_WIDTH-1:0];
    end
  end

  // ****************************************
  // Status change detection
  // ****************************************
  // The previous samples are only trusted once a first sample has been
  // taken after reset, so the level present at release is not a change.
  logic port_valid_prev_reg;
  logic lock_prev_reg;
  logic prev_ok_reg;
  logic port_valid_changed;
  logic lock_changed;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      port_valid_prev_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
      prev_ok_reg <= 1'b0;
    end else begin
      port_valid_prev_reg <= PORT_VALID_I;
      lock_prev_reg <= LOCK_I;
      prev_ok_reg <= 1'b1;
    end
  end

  assign port_valid_changed = prev_ok_reg && (PORT_VALID_I != port_valid_prev_reg);
  assign lock_changed = prev_ok_reg && (LOCK_I != lock_prev_reg);

  // ****************************************
  // Interrupt status flags
  // ****************************************
  logic [RPI_EVENT_COUNT-1:0] event_vec;
  logic [RPI_EVENT_COUNT-1:0] enable_vec;
  logic [RPI_EVENT_COUNT-1:0] clear_vec;
  logic [RPI_EVENT_COUNT-1:0] flag_vec;

  always_comb begin
    event_vec = '0;
    event_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_SEQUENCE_ERROR] = CTL_SEQUENCE_ERROR_I;
    event_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_CRC_ERROR] = CTL_CRC_ERROR_I;
    event_vec[RPI_IDX_HIGH_BASE + RPI_BIT_ENCODE_ERROR] = ENCODE_ERROR_I;
    event_vec[RPI_IDX_LOW_BASE + RPI_BIT_PARITY_ERROR] = PARITY_ERROR_I;
    event_vec[RPI_IDX_LOW_BASE + RPI_BIT_PORT_VALID] = port_valid_changed;
    event_vec[RPI_IDX_LOW_BASE + RPI_BIT_LOCK_CHANGE] = lock_changed;
  end

  assign enable_vec = {enable_high_reg, enable_low_reg};

  always_comb begin
    clear_vec = '0;
    clear_vec[RPI_IDX_HIGH_BASE + RPI_BIT_ENCODE_ERROR] = STATUS_TWO_READ_I;
    clear_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_SEQUENCE_ERROR] = STATUS_ONE_READ_I;
    clear_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_CRC_ERROR] = STATUS_ONE_READ_I;
    clear_vec[RPI_IDX_LOW_BASE + RPI_BIT_PARITY_ERROR] = STATUS_ONE_READ_I;
    clear_vec[RPI_IDX_LOW_BASE + RPI_BIT_PORT_VALID] = STATUS_ONE_READ_I;
    clear_vec[RPI_IDX_LOW_BASE + RPI_BIT_LOCK_CHANGE] = STATUS_ONE_READ_I;
  end

  genvar gi;
  generate
    for (gi = 0; gi < RPI_EVENT_COUNT; gi++) begin : g_flag
      rpi_flag_cell u_flag (
        .clk_i(REF_CLK_I),
        .rst_b_i(RST_B_I),
        .enable_i(enable_vec[gi]),
        .event_i(event_vec[gi]),
        .clear_i(clear_vec[gi]),
        .flag_o(flag_vec[gi])
      );
    end
  endgenerate

  // ****************************************
  // Interrupt request
  // ****************************************
  // A stored flag whose enable has been cleared stays stored but no longer requests.
  logic encode_error_irq_enable;
  logic ctl_sequence_error_irq_enable;
  logic ctl_crc_error_irq_enable;
  logic parity_error_irq_enable;
  logic port_valid_irq_enable;
  logic lock_change_irq_enable;
  logic encode_error_irq_flag;
  logic ctl_sequence_error_irq_flag;
  logic ctl_crc_error_irq_flag;
  logic parity_error_irq_flag;
  logic port_valid_irq_flag;
  logic lock_change_irq_flag;
  logic [RPI_EVENT_COUNT-1:0] pending_vec;

  assign encode_error_irq_enable = enable_vec[RPI_IDX_HIGH_BASE + RPI_BIT_ENCODE_ERROR];
  assign ctl_sequence_error_irq_enable = enable_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_SEQUENCE_ERROR];
  assign ctl_crc_error_irq_enable = enable_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_CRC_ERROR];
  assign parity_error_irq_enable = enable_vec[RPI_IDX_LOW_BASE + RPI_BIT_PARITY_ERROR];
  assign port_valid_irq_enable = enable_vec[RPI_IDX_LOW_BASE + RPI_BIT_PORT_VALID];
  assign lock_change_irq_enable = enable_vec[RPI_IDX_LOW_BASE + RPI_BIT_LOCK_CHANGE];
  assign encode_error_irq_flag = flag_vec[RPI_IDX_HIGH_BASE + RPI_BIT_ENCODE_ERROR];
  assign ctl_sequence_error_irq_flag = flag_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_SEQUENCE_ERROR];
  assign ctl_crc_error_irq_flag = flag_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_CRC_ERROR];
  assign parity_error_irq_flag = flag_vec[RPI_IDX_LOW_BASE + RPI_BIT_PARITY_ERROR];
  assign port_valid_irq_flag = flag_vec[RPI_IDX_LOW_BASE + RPI_BIT_PORT_VALID];
  assign lock_change_irq_flag = flag_vec[RPI_IDX_LOW_BASE + RPI_BIT_LOCK_CHANGE];

  always_comb begin
    pending_vec = '0;
    pending_vec[RPI_IDX_HIGH_BASE + RPI_BIT_ENCODE_ERROR] =
      encode_error_irq_flag && encode_error_irq_enable;
    pending_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_SEQUENCE_ERROR] =
      ctl_sequence_error_irq_flag && ctl_sequence_error_irq_enable;
    pending_vec[RPI_IDX_HIGH_BASE + RPI_BIT_CTL_CRC_ERROR] =
      ctl_crc_error_irq_flag && ctl_crc_error_irq_enable;
    pending_vec[RPI_IDX_LOW_BASE + RPI_BIT_PARITY_ERROR] =
      parity_error_irq_flag && parity_error_irq_enable;
    pending_vec[RPI_IDX_LOW_BASE + RPI_BIT_PORT_VALID] =
      port_valid_irq_flag && port_valid_irq_enable;
    pending_vec[RPI_IDX_LOW_BASE + RPI_BIT_LOCK_CHANGE] =
      lock_change_irq_flag && lock_change_irq_enable;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |pending_vec;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = RPI_READ_IDLE;
    case (sel)
      RPI_SEL_ENABLE_HIGH: begin
        rdata_next[RPI_FIELD_WIDTH-1:0] = enable_high_reg;
      end
      RPI_SEL_ENABLE_LOW: begin
        rdata_next[RPI_FIELD_WIDTH-1:0] = enable_low_reg;
      end
      RPI_SEL_STATUS_HIGH: begin
        rdata_next[RPI_FIELD_WIDTH-1:0] = flag_vec[RPI_IDX_HIGH_BASE +: RPI_FIELD_WIDTH];
      end
      RPI_SEL_STATUS_LOW: begin
        rdata_next[RPI_FIELD_WIDTH-1:0] = flag_vec[RPI_IDX_LOW_BASE +: RPI_FIELD_WIDTH];
      end
      default: begin
        rdata_next = RPI_READ_IDLE;
      end
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  // status readout
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O <= RPI_READ_IDLE;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rdata_next;
    end
  end

endmodule

/* rpi_pkg.sv */
// Constants shared by the receive-port interrupt enable and status logic.
package rpi_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] RPI_ADDR_ENABLE_HIGH = 8'hD8;
  localparam logic [7:0] RPI_ADDR_ENABLE_LOW = 8'hD9;
  localparam logic [7:0] RPI_ADDR_STATUS_HIGH = 8'hDA;
  localparam logic [7:0] RPI_ADDR_STATUS_LOW = 8'hDB;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RPI_ENABLE_RESET = 8'h00;
  localparam logic [7:0] RPI_READ_IDLE = 8'h00;

  // ****************************************
  // Field positions, high registers
  // ****************************************
  localparam int RPI_BIT_ENCODE_ERROR = 2;
  localparam int RPI_BIT_CTL_SEQUENCE_ERROR = 1;
  localparam int RPI_BIT_CTL_CRC_ERROR = 0;

  // ****************************************
  // Field positions, low registers
  // ****************************************
  localparam int RPI_BIT_PARITY_ERROR = 2;
  localparam int RPI_BIT_PORT_VALID = 1;
  localparam int RPI_BIT_LOCK_CHANGE = 0;

  // Number of implemented bits in each register; bits above read as zero.
  localparam int RPI_FIELD_WIDTH = 3;

  // Index of each event in the flat six-bit event vector.
  localparam int RPI_EVENT_COUNT = 6;
  localparam int RPI_IDX_LOW_BASE = 0;
  localparam int RPI_IDX_HIGH_BASE = 3;

  // Register selector decoded from the bus address.
  typedef enum logic [2:0] {
    RPI_SEL_NONE,
    RPI_SEL_ENABLE_HIGH,
    RPI_SEL_ENABLE_LOW,
    RPI_SEL_STATUS_HIGH,
    RPI_SEL_STATUS_LOW
  } rpi_sel_t;

endpackage

/* rpi_flag_cell.sv */
// One sticky interrupt status flag with enable gating and read clear.
`timescale 1ns/10ps
module rpi_flag_cell (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic event_i,
  input wire logic clear_i,
  output logic flag_o
);

  logic flag_reg;
  logic flag_next;

  // A new event wins over a clear in the same cycle, and only an enabled
  // event can set the flag.
  always_comb begin
    flag_next = flag_reg;
    if (clear_i) begin
      flag_next = 1'b0;
    end
    if (enable_i && event_i) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;

endmodule

/* rpi_port_irq_sva.sv */
// Assertion checker for the receive-port interrupt block.
`timescale 1ns/10ps
module rpi_port_irq_chk
  import rpi_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic ENCODE_ERROR_I,
  input wire logic CTL_SEQUENCE_ERROR_I,
  input wire logic CTL_CRC_ERROR_I,
  input wire logic PARITY_ERROR_I,
  input wire logic PORT_VALID_I,
  input wire logic LOCK_I,
  input wire logic STATUS_ONE_READ_I,
  input wire logic STATUS_TWO_READ_I,
  input wire logic IRQ_O
);
  logic [2:0] en_hi_reg;
  logic [2:0] en_lo_reg;
  logic armed_reg;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Level changes count only once the reference levels have been taken.
  always_ff @(posedge REF_CLK_I) begin
    armed_reg <= RST_B_I;
  end
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      en_hi_reg <= 3'h0;
      en_lo_reg <= 3'h0;
    end else if (REG_WR_I && REG_ADDR_I == RPI_ADDR_ENABLE_HIGH) begin
      en_hi_reg <= REG_WDATA_I[2:0];
    end else if (REG_WR_I && REG_ADDR_I == RPI_ADDR_ENABLE_LOW) begin
      en_lo_reg <= REG_WDATA_I[2:0];
    end
  end
  sequence s_enc;
    ENCODE_ERROR_I && en_hi_reg[2] && !REG_WR_I ##1 !REG_WR_I && !STATUS_TWO_READ_I;
  endsequence
  sequence s_clear;
    STATUS_ONE_READ_I && STATUS_TWO_READ_I && !ENCODE_ERROR_I && !CTL_SEQUENCE_ERROR_I
      && !CTL_CRC_ERROR_I && !PARITY_ERROR_I && $stable(PORT_VALID_I) && $stable(LOCK_I);
  endsequence
  property p_hold;
    !REG_RD_I |=> $stable(REG_RDATA_O);
  endproperty
  property p_unmapped;
    REG_RD_I && (REG_ADDR_I < RPI_ADDR_ENABLE_HIGH || REG_ADDR_I > RPI_ADDR_STATUS_LOW)
      |=> REG_RDATA_O == RPI_READ_IDLE;
  endproperty
  property p_rd_en;
    REG_RD_I && REG_ADDR_I == RPI_ADDR_ENABLE_LOW |=> REG_RDATA_O == {5'h00, $past(en_lo_reg)};
  endproperty
  property p_crc;
    CTL_CRC_ERROR_I && en_hi_reg[0] && !REG_WR_I |-> ##2 IRQ_O;
  endproperty
  property p_lock;
    armed_reg && $changed(LOCK_I) && en_lo_reg[0] && !REG_WR_I |-> ##2 IRQ_O;
  endproperty
  property p_seq;
    CTL_SEQUENCE_ERROR_I && en_hi_reg[1] && !REG_WR_I |-> ##2 IRQ_O;
  endproperty
  property p_valid;
    armed_reg && $changed(PORT_VALID_I) && en_lo_reg[1] && !REG_WR_I |-> ##2 IRQ_O;
  endproperty
  property p_enc;
    s_enc |=> IRQ_O [*2];
  endproperty
  property p_off;
    en_hi_reg == 3'h0 && en_lo_reg == 3'h0 |=> !IRQ_O;
  endproperty
  property p_clear;
    s_clear |=> ##1 !IRQ_O;
  endproperty
  a_hold: assert property (p_hold) else $error("read data changed without a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rd_en: assert property (p_rd_en) else $error("low enable readback wrong");
  a_crc: assert property (p_crc) else $error("crc event gave no request");
  a_lock: assert property (p_lock) else $error("lock change gave no request");
  a_seq: assert property (p_seq) else $error("sequence event gave no request");
  a_valid: assert property (p_valid) else $error("valid change gave no request");
  a_enc: assert property (p_enc) else $error("encode flag lost early");
  a_off: assert property (p_off) else $error("request with all disabled");
  a_clear: assert property (p_clear) else $error("request after full clear");
endmodule

/* rpi_port_irq_bench.sv */
// Self-checking bench for the receive-port interrupt block.
`timescale 1ns/10ps
module rpi_port_irq_bench;
  import rpi_pkg::*;
  logic clk, rst_b, wr, rd, enc, seq, crc, par, valid, lock, st1, st2, irq;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] en, fl;
  integer seed, failures, samples_checked, i, r;
  rpi_port_irq dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ENCODE_ERROR_I(enc),
    .CTL_SEQUENCE_ERROR_I(seq), .CTL_CRC_ERROR_I(crc), .PARITY_ERROR_I(par),
    .PORT_VALID_I(valid), .LOCK_I(lock), .STATUS_ONE_READ_I(st1),
    .STATUS_TWO_READ_I(st2), .IRQ_O(irq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [5:0] next_flags(logic [5:0] f, logic [7:0] v, logic [5:0] e);
    return (f & ~({v[7], 5'h00} | {1'b0, {5{v[6]}}})) | (v[5:0] & e);
  endfunction
  task chk(input logic [7:0] v, input logic [7:0] e);
    samples_checked++;
    if (v !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == RPI_ADDR_ENABLE_HIGH) en[5:3] = d[2:0];
    if (a == RPI_ADDR_ENABLE_LOW) en[2:0] = d[2:0];
  endtask
  task rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // Bits 5:2 pulse the error events, 1:0 toggle valid and lock, 7:6 pulse the clears.
  task evt(input logic [7:0] v);
    @(posedge clk);
    {enc, seq, crc, par} <= v[5:2];
    valid <= valid ^ v[1];
    lock <= lock ^ v[0];
    {st2, st1} <= v[7:6];
    @(posedge clk);
    {enc, seq, crc, par, st2, st1} <= 6'h00;
    fl = next_flags(fl, v, en);
  endtask
  task cmp_all;
    rreg(RPI_ADDR_ENABLE_HIGH, {5'h00, en[5:3]});
    rreg(RPI_ADDR_ENABLE_LOW, {5'h00, en[2:0]});
    rreg(RPI_ADDR_STATUS_HIGH, {5'h00, fl[5:3]});
    rreg(RPI_ADDR_STATUS_LOW, {5'h00, fl[2:0]});
    chk({7'h00, irq}, {7'h00, |(fl & en)});
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    seed = 32'h1de1;
    failures = 0;
    samples_checked = 0;
    {rst_b, wr, rd, enc, seq, crc, par, valid, lock, st1, st2} = 11'h000;
    {addr, wdata, en, fl} = 28'h0000000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    cmp_all;
    wreg(8'hD8, 8'hF9);
    evt(8'h3F);
    cmp_all;
    evt(8'h80);
    cmp_all;
    evt(8'h40);
    cmp_all;
    evt(8'hC8);
    cmp_all;
    wreg(8'hD8, 8'h04);
    evt(8'h60);
    cmp_all;
    evt(8'h80);
    cmp_all;
    wreg(8'hD9, 8'h07);
    evt(8'h07);
    cmp_all;
    evt(8'hC0);
    cmp_all;
    wreg(8'hD8, 8'h02);
    evt(8'h10);
    cmp_all;
    evt(8'h40);
    cmp_all;
    wreg(8'hDA, 8'h07);
    rreg(8'hDC, 8'h00);
    rreg(8'h00, 8'h00);
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      if (r[0]) wreg(r[1] ? RPI_ADDR_ENABLE_HIGH : RPI_ADDR_ENABLE_LOW, r[15:8]);
      else evt(r[15:8]);
      cmp_all;
    end
    end_of_test;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    end_of_test;
  end
endmodule
bind rpi_port_irq rpi_port_irq_chk chk_i (
  .REF_CLK_I(REF_CLK_I),
  .RST_B_I(RST_B_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O),
  .ENCODE_ERROR_I(ENCODE_ERROR_I),
  .CTL_SEQUENCE_ERROR_I(CTL_SEQUENCE_ERROR_I),
  .CTL_CRC_ERROR_I(CTL_CRC_ERROR_I),
  .PARITY_ERROR_I(PARITY_ERROR_I),
  .PORT_VALID_I(PORT_VALID_I),
  .LOCK_I(LOCK_I),
  .STATUS_ONE_READ_I(STATUS_ONE_READ_I),
  .STATUS_TWO_READ_I(STATUS_TWO_READ_I),
  .IRQ_O(IRQ_O)
);
